/* acs_chan.v */
// One comparator channel: gated result and sticky change flag
`timescale 1ns/1ps
module acs_chan (
    input wire sys_clk,
    input wire rst,
    input wire raw_in,
    input wire enable,
    input wire flag_clr,
    output reg result_ff,
    output reg flag_ff
);
    wire sync_out;
    reg prev_ff;
    wire changed;
    reg nxt_flag;

    acs_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(raw_in),
        .dout(sync_out)
    );

    // A change is the synchronised level differing from last cycle
    assign changed = enable & (sync_out ^ prev_ff);

    // Set has priority so an edge in the clearing cycle is kept
    always @* begin
        nxt_flag = flag_ff;
        if (flag_clr) begin
            nxt_flag = 1'b0;
        end
        if (changed) begin
            nxt_flag = 1'b1;
        end
    end

    // History, flag and visible result
    always @(posedge sys_clk) begin
        if (rst) begin
            prev_ff <= 1'b0;
            flag_ff <= 1'b0;
            result_ff <= 1'b0;
        end else begin
            prev_ff <= enable ? sync_out : 1'b0;
            flag_ff <= nxt_flag;
            result_ff <= enable & sync_out;
        end
    end
endmodule

/* acs_checker.sv */
// Assertion checker for the comparator status block
`timescale 1ns/1ps
module acs_checker (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire cmp0_enable_ff,
    input wire cmp1_enable_ff,
    input wire ref_sel_ff,
    input wire [3:0] reference_level_setting_ff,
    input wire irq_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Write and read-setup qualifiers
    wire wr = psel && penable && pwrite;
    wire rs = psel && !penable && !pwrite;
    reg [31:0] last_wd_ff;
    // Keeps the write data of the access edge for the next-cycle checks
    always @(posedge sys_clk) begin
        last_wd_ff <= pwdata;
    end
    AST_PREADY: assert property (pready) else $error("pready low");
    AST_REF_RST: assert property ($fell(rst) |-> !ref_sel_ff && reference_level_setting_ff == 4'h0)
        else $error("reference not reset");
    AST_REF_WR: assert property (wr && paddr == 12'h00c |=> ref_sel_ff == last_wd_ff[7] &&
        reference_level_setting_ff == last_wd_ff[3:0]) else $error("reference write lost");
    AST_EN0_WR: assert property (wr && paddr == 12'h000 |=> cmp0_enable_ff == last_wd_ff[0])
        else $error("enable 0 write lost");
    AST_EN1_WR: assert property (wr && paddr == 12'h004 |=> cmp1_enable_ff == last_wd_ff[0])
        else $error("enable 1 write lost");
    AST_REF_RD: assert property (rs && paddr == 12'h00c |=>
        prdata == {24'h0, ref_sel_ff, 3'h0, reference_level_setting_ff}) else $error("reference read bad");
    AST_ST_RD: assert property (rs && paddr == 12'h008 |=> prdata[31:4] == 28'h0 &&
        (cmp1_enable_ff || !prdata[3]) && (cmp0_enable_ff || !prdata[2])) else $error("status read bad");
    AST_SLVERR: assert property (rs && paddr == 12'h100 |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    cover property (wr && paddr == 12'h008);
    cover property ($rose(irq_ff));
    cover property (rs && paddr == 12'h00c);
endmodule
bind acs_top acs_checker i_acs_checker (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmp0_enable_ff(cmp0_enable_ff), .cmp1_enable_ff(cmp1_enable_ff), .ref_sel_ff(ref_sel_ff),
    .reference_level_setting_ff(reference_level_setting_ff), .irq_ff(irq_ff));

/* acs_cmp_model.sv */
// Behavioural model of the two analog comparators
`timescale 1ns/1ps
module acs_cmp_model #(parameter real DLY = 1.3) (
    input wire logic [1:0] level,
    output wire logic cmp0_raw,
    output wire logic cmp1_raw
);
    // Outputs move off the bus clock grid, so the synchroniser sees true async edges
    assign #(DLY) {cmp1_raw, cmp0_raw} = level;
endmodule

/* acs_defs.vh */
// Register map, field positions and reset values for the comparator status block
//
// Behaviour
// - Status bit 3 shows synchronised comparator 1 output, zero when comparator 1 disabled.
// - Status bit 2 shows synchronised comparator 0 output, zero when comparator 0 disabled.
// - Status bit 1 sets on every comparator 1 output change while comparator 1 enabled, holds until cleared.
// - Status bit 0 sets on every comparator 0 output change while comparator 0 enabled, holds until cleared.
// - Interrupt requested while comparator 1 flag set, its interrupt enable is one and interrupt mask bit 1 is one.
// - Interrupt requested while comparator 0 flag set, its interrupt enable is one and interrupt mask bit 0 is one.
// - Writing one to a change flag clears it; writing zero leaves it.
// - Reference control bit 7 selects band-gap (0) or programmable reference (1).
// - Reference bits 3:0 give the level setting, driven to the reference generator.
// - Reference control resets to zero; bits 31:8 and 6:4 reserved, read zero.
// - Each comparator control register has its enable at bit 0.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ACS_OFF_CMP0_CTRL 12'h000
`define ACS_OFF_CMP1_CTRL 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_REF_CTRL 12'h00c
`define ACS_OFF_IRQ_MASK 12'h010

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ACS_CTRL_EN_BIT 0
`define ACS_CTRL_IE_BIT 1
`define ACS_ST_FLAG0_BIT 0
`define ACS_ST_FLAG1_BIT 1
`define ACS_ST_RES0_BIT 2
`define ACS_ST_RES1_BIT 3
`define ACS_REF_SEL_BIT 7
`define ACS_REF_LVL_MSB 3
`define ACS_REF_LVL_LSB 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ACS_RST_CTRL 2'h0
`define ACS_RST_REF_SEL 1'h0
`define ACS_RST_REF_LVL 4'h0
`define ACS_RST_MASK 2'h3

`endif

/* acs_sync.v */
// Two-flop synchroniser for one comparator output
`timescale 1ns/1ps
module acs_sync (
    input wire sys_clk,
    input wire rst,
    input wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // First stage is read only by the second stage
    always @(posedge sys_clk) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* acs_top.v */
// Comparator status and reference control with APB slave
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_top (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire cmp0_raw,
    input wire cmp1_raw,
    output reg cmp0_enable_ff,
    output reg cmp1_enable_ff,
    output reg ref_sel_ff,
    output reg [3:0] reference_level_setting_ff,
    output reg irq_ff
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg cmp0_irq_enable_ff;
    reg cmp1_irq_enable_ff;
    reg [1:0] irq_mask_ff;
    wire cmp0_result;
    wire cmp1_result;
    wire cmp0_change_flag;
    wire cmp1_change_flag;
    wire setup;
    wire access;
    wire wr_en;
    wire hit_ctrl0;
    wire hit_ctrl1;
    wire hit_stat;
    wire hit_ref;
    wire hit_mask;
    wire mapped;
    wire clr0;
    wire clr1;
    reg [31:0] nxt_rdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero-wait slave: pready held high by a flop so the output comes straight from a register
    always @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b1;
        end else begin
            pready <= 1'b1;
        end
    end

    // Read data registered in setup
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_en = access & pwrite;
    assign hit_ctrl0 = (paddr == `ACS_OFF_CMP0_CTRL);
    assign hit_ctrl1 = (paddr == `ACS_OFF_CMP1_CTRL);
    assign hit_stat = (paddr == `ACS_OFF_STATUS);
    assign hit_ref = (paddr == `ACS_OFF_REF_CTRL);
    assign hit_mask = (paddr == `ACS_OFF_IRQ_MASK);
    assign mapped = hit_ctrl0 | hit_ctrl1 | hit_stat | hit_ref | hit_mask;
    assign clr0 = wr_en & hit_stat & pwdata[`ACS_ST_FLAG0_BIT];
    assign clr1 = wr_en & hit_stat & pwdata[`ACS_ST_FLAG1_BIT];

    // ------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------
    acs_chan u_ch0 (
        .sys_clk(sys_clk),
        .rst(rst),
        .raw_in(cmp0_raw),
        .enable(cmp0_enable_ff),
        .flag_clr(clr0),
        .result_ff(cmp0_result),
        .flag_ff(cmp0_change_flag)
    );

    acs_chan u_ch1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .raw_in(cmp1_raw),
        .enable(cmp1_enable_ff),
        .flag_clr(clr1),
        .result_ff(cmp1_result),
        .flag_ff(cmp1_change_flag)
    );

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Writes land at the access edge only
    always @(posedge sys_clk) begin
        if (rst) begin
            cmp0_enable_ff <= 1'b0;
            cmp0_irq_enable_ff <= 1'b0;
            cmp1_enable_ff <= 1'b0;
            cmp1_irq_enable_ff <= 1'b0;
            ref_sel_ff <= `ACS_RST_REF_SEL;
            reference_level_setting_ff <= `ACS_RST_REF_LVL;
            irq_mask_ff <= `ACS_RST_MASK;
        end else if (wr_en) begin
            if (hit_ctrl0) begin
                cmp0_enable_ff <= pwdata[`ACS_CTRL_EN_BIT];
                cmp0_irq_enable_ff <= pwdata[`ACS_CTRL_IE_BIT];
            end
            if (hit_ctrl1) begin
                cmp1_enable_ff <= pwdata[`ACS_CTRL_EN_BIT];
                cmp1_irq_enable_ff <= pwdata[`ACS_CTRL_IE_BIT];
            end
            if (hit_ref) begin
                ref_sel_ff <= pwdata[`ACS_REF_SEL_BIT];
                reference_level_setting_ff <= pwdata[`ACS_REF_LVL_MSB:`ACS_REF_LVL_LSB];
            end
            if (hit_mask) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Reserved bits read as zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (hit_ctrl0) begin
            nxt_rdata[`ACS_CTRL_EN_BIT] = cmp0_enable_ff;
            nxt_rdata[`ACS_CTRL_IE_BIT] = cmp0_irq_enable_ff;
        end
        if (hit_ctrl1) begin
            nxt_rdata[`ACS_CTRL_EN_BIT] = cmp1_enable_ff;
            nxt_rdata[`ACS_CTRL_IE_BIT] = cmp1_irq_enable_ff;
        end
        if (hit_stat) begin
            nxt_rdata[`ACS_ST_RES1_BIT] = cmp1_result;
            nxt_rdata[`ACS_ST_RES0_BIT] = cmp0_result;
            nxt_rdata[`ACS_ST_FLAG1_BIT] = cmp1_change_flag;
            nxt_rdata[`ACS_ST_FLAG0_BIT] = cmp0_change_flag;
        end
        if (hit_ref) begin
            nxt_rdata[`ACS_REF_SEL_BIT] = ref_sel_ff;
            nxt_rdata[`ACS_REF_LVL_MSB:`ACS_REF_LVL_LSB] = reference_level_setting_ff;
        end
        if (hit_mask) begin
            nxt_rdata[1:0] = irq_mask_ff;
        end
    end

    // Read data and error captured in setup so access phase sees stable values
    always @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : nxt_rdata;
            pslverr <= ~mapped;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Level output: enable bits and mask both gate each sticky flag
    always @(posedge sys_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (cmp1_change_flag & cmp1_irq_enable_ff & irq_mask_ff[1])
                    | (cmp0_change_flag & cmp0_irq_enable_ff & irq_mask_ff[0]);
        end
    end
endmodule

/* acs_top_tb.sv */
// Self-checking testbench for the comparator status block
`timescale 1ns/1ps
module acs_top_tb;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq_ff;
    logic cmp0_raw, cmp1_raw, cmp0_enable_ff, cmp1_enable_ff, ref_sel_ff;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [1:0] level, l, p;
    logic [3:0] reference_level_setting_ff;
    logic [33:0] exp_q[$];
    int num_errors = 0;
    int comparisons = 0;
    acs_top i_acs_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cmp0_raw(cmp0_raw), .cmp1_raw(cmp1_raw), .cmp0_enable_ff(cmp0_enable_ff),
        .cmp1_enable_ff(cmp1_enable_ff), .ref_sel_ff(ref_sel_ff),
        .reference_level_setting_ff(reference_level_setting_ff), .irq_ff(irq_ff));
    acs_cmp_model i_acs_cmp_model (.level(level), .cmp0_raw(cmp0_raw), .cmp1_raw(cmp1_raw));
    // ----
    // Clock and bus tasks
    // ----
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task end_sim;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task fail(input string m);
        num_errors++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    // Bounded wait on pready, so a dead slave ends the run instead of hanging
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) begin
            fail("no pready");
            end_sim;
        end
    endtask
    // Expected value holds {pslverr, irq, read data}
    task rd(input logic [11:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Eight cycles cover the synchroniser, flag and interrupt delays
    task raw(input logic [1:0] v);
        level <= v;
        repeat (8) @(posedge sys_clk);
    endtask
    // Monitor compares each completed read against the oldest note
    always @(posedge sys_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            comparisons++;
            if (exp_q.size() == 0) begin
                fail("unexpected read");
            end else if ({pslverr, irq_ff, prdata} !== exp_q.pop_front()) begin
                fail("read data mismatch");
            end
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        level = 2'h0;
        d = $urandom(32'h0080);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h00c, 34'h0);
        rd(12'h008, 34'h0);
        rd(12'h010, {2'b00, 32'h3});
        rd(12'h100, {2'b10, 32'h0});
        for (int i = 0; i < 6; i++) begin
            d = $urandom();
            apb(1'b1, 12'h00c, d);
            rd(12'h00c, {2'b00, d & 32'h0000008f});
        end
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b1, 12'h004, 32'h3);
        raw(2'b01);
        rd(12'h008, {2'b01, 32'h5});
        apb(1'b1, 12'h008, 32'h1);
        raw(2'b11);
        rd(12'h008, {2'b01, 32'he});
        apb(1'b1, 12'h010, 32'h1);
        rd(12'h008, {2'b00, 32'he});
        apb(1'b1, 12'h010, 32'h3);
        apb(1'b1, 12'h008, 32'h0);
        rd(12'h008, {2'b01, 32'he});
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        raw(2'b10);
        rd(12'h008, {2'b00, 32'h9});
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        rd(12'h008, {2'b00, 32'h1});
        raw(2'b00);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b1, 12'h008, 32'h3);
        p = 2'b00;
        // Random levels: each changed output must leave its flag and raise the interrupt
        for (int i = 0; i < 10; i++) begin
            l = 2'($urandom());
            raw(l);
            rd(12'h008, {1'b0, |(l ^ p), 28'h0, l, l ^ p});
            apb(1'b1, 12'h008, 32'h3);
            p = l;
        end
        end_sim;
    end
endmodule
